// ### tae_defines.svh
`ifndef TAE_DEFINES_SVH
`define TAE_DEFINES_SVH

// Register byte offsets
`define TAE_OFF_MSTATE 8'h00
`define TAE_OFF_SRPC 8'h04
`define TAE_OFF_SRSTATE 8'h08
`define TAE_OFF_TSTATUS 8'h0c
`define TAE_OFF_TCTRL 8'h10
`define TAE_OFF_CDOWN 8'h14
`define TAE_OFF_RELOAD 8'h18

// Machine state bit positions
`define TAE_MS_AUX 25
`define TAE_MS_AUXEXC 19
`define TAE_MS_WAIT 18
`define TAE_MS_CRIT 17
`define TAE_MS_EXTIRQ 15
`define TAE_MS_USER 14
`define TAE_MS_FLOAT 13
`define TAE_MS_MCHK 12
`define TAE_MS_FE_LO 11
`define TAE_MS_DBGWAIT 10
`define TAE_MS_DBG 9
`define TAE_MS_FE_HI 8
`define TAE_MS_ITRANS 5
`define TAE_MS_DTRANS 4

// Timer status and control bit positions
`define TAE_TS_CDOWN 27
`define TAE_TS_FTICK 26
`define TAE_TC_CDOWN_EN 26
`define TAE_TC_FSEL_HI 25
`define TAE_TC_FSEL_LO 24
`define TAE_TC_FTICK_EN 23
`define TAE_TC_RELOAD 22

// Vector offsets
`define TAE_VEC_AUX 16'h0f20
`define TAE_VEC_CDOWN 16'h1000
`define TAE_VEC_FTICK 16'h1010

// Reset values
`define TAE_RST_WORD 32'h0000_0000

`endif

// ### tae_pkg.sv
package tae_pkg;

    // Cause of an entry
    typedef enum logic [1:0] {
        TAE_CAUSE_NONE = 2'b00,
        TAE_CAUSE_AUX = 2'b01,
        TAE_CAUSE_CDOWN = 2'b10,
        TAE_CAUSE_FTICK = 2'b11
    } tae_cause_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } tae_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tae_apb_rsp_t;

    // Entry notice to the pipeline
    typedef struct packed {
        logic valid;
        tae_cause_t cause;
        logic [15:0] vector;
    } tae_entry_t;

endpackage

// ### tae_exception_entry.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "tae_defines.svh"
module tae_exception_entry
    import tae_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Register bus
    input wire tae_apb_req_t apb_i,
    output tae_apb_rsp_t apb_o,
    // Pipeline side
    input wire logic aux_exec_i,
    input wire logic [31:0] aux_ea_i,
    input wire logic [31:0] next_pc_i,
    input wire logic rfi_i,
    // Timer side
    input wire logic cdown_dec_i,
    input wire logic [3:0] tb_bits_i,
    // Entry notice and state view
    output tae_entry_t entry_o,
    output logic [31:0] machine_state_o
);

    // Everything runs on the one core clock; there is no clock enable
    // All inputs come from logic on that clock, so none is synchronised

    // Architected state, reached by software over the register bus
    logic [31:0] machine_state_reg_r; // Machine state
    logic [31:0] save_restore_pc_r; // Return address
    logic [31:0] save_restore_state_r; // Saved state
    logic [31:0] timer_status_reg_r; // Sticky timer flags
    logic [31:0] timer_control_reg_r; // Timer enables
    logic [31:0] interval_countdown_r; // Countdown value
    logic [31:0] cdown_reload_r; // Auto-reload value
    // Tick edge detection
    // The armed flag keeps reset from looking like a rising edge
    logic tb_prev_r; // Last selected time-base bit
    logic tb_armed_r; // Prev bit is valid
    // Bus answer registers
    logic [31:0] prdata_r;
    logic pslverr_r;
    // Entry notice register
    tae_entry_t entry_r;

    // Combinational helpers
    // None of these is stored; each settles within the cycle
    logic bus_wr; // Write taken this edge
    logic bus_setup; // Setup cycle
    logic cdown_timeout; // Countdown expiry event
    logic tb_sel; // Selected time-base bit
    logic ftick_event; // Tick event
    logic ext_on; // External enable from the machine state
    logic cdown_req; // Countdown request
    logic ftick_req; // Tick request
    logic take; // Entry this edge
    tae_cause_t cause; // Chosen cause
    logic [15:0] vec; // Chosen vector
    logic [31:0] tsr_set; // Hardware set mask

    // Address decode, used for reads and writes
    // Upper bits must be zero, so no alias of a register answers
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
    endfunction

    // Known address check
    function automatic logic mapped(input logic [31:0] a);
        mapped = hit(a, `TAE_OFF_MSTATE) || hit(a, `TAE_OFF_SRPC) ||
                 hit(a, `TAE_OFF_SRSTATE) || hit(a, `TAE_OFF_TSTATUS) ||
                 hit(a, `TAE_OFF_TCTRL) || hit(a, `TAE_OFF_CDOWN) ||
                 hit(a, `TAE_OFF_RELOAD);
    endfunction

    // State after entry: listed bits cleared, others kept
    // Critical, machine-check and debug enables pass through unchanged
    function automatic logic [31:0] entry_state(input logic [31:0] s);
        logic [31:0] r;
        r = s;
        r[`TAE_MS_AUX] = 1'b0;
        r[`TAE_MS_AUXEXC] = 1'b0;
        r[`TAE_MS_WAIT] = 1'b0;
        r[`TAE_MS_EXTIRQ] = 1'b0;
        r[`TAE_MS_USER] = 1'b0;
        r[`TAE_MS_FLOAT] = 1'b0;
        r[`TAE_MS_FE_LO] = 1'b0;
        r[`TAE_MS_DBGWAIT] = 1'b0;
        r[`TAE_MS_FE_HI] = 1'b0;
        r[`TAE_MS_ITRANS] = 1'b0;
        r[`TAE_MS_DTRANS] = 1'b0;
        entry_state = r;
    endfunction

    // Bus phase decode
    // Writes act in the access cycle only, never at setup
    assign bus_setup = apb_i.psel & ~apb_i.penable;
    assign bus_wr = apb_i.psel & apb_i.penable & apb_i.pwrite;

    // Countdown expires only on a real decrement from one
    // A decrement at zero is no expiry, so a stopped counter stays quiet
    always_comb begin
        cdown_timeout = cdown_dec_i && (interval_countdown_r == 32'h0000_0001);
        // A bus write to the countdown overrides the decrement
        if (bus_wr && hit(apb_i.paddr, `TAE_OFF_CDOWN)) begin
            cdown_timeout = 1'b0;
        end
    end

    // Tick bit select and rising edge
    // Moving the select can itself make an edge; mask the tick first
    // when changing the period
    assign tb_sel = tb_bits_i[timer_control_reg_r[`TAE_TC_FSEL_HI:`TAE_TC_FSEL_LO]];
    assign ftick_event = tb_armed_r & ~tb_prev_r & tb_sel;

    // Hardware flag sets touch their own bit only
    // Built as a mask so the status update is a single OR
    always_comb begin
        tsr_set = 32'h0000_0000;
        tsr_set[`TAE_TS_CDOWN] = cdown_timeout;
        tsr_set[`TAE_TS_FTICK] = ftick_event;
    end

    // Requests come from sticky flags and both enables
    // The level of the flag, not the event, drives the request,
    // so a request left pending is taken once the state returns
    assign ext_on = machine_state_reg_r[`TAE_MS_EXTIRQ];
    assign cdown_req = timer_status_reg_r[`TAE_TS_CDOWN] &
                       timer_control_reg_r[`TAE_TC_CDOWN_EN] & ext_on;
    assign ftick_req = timer_status_reg_r[`TAE_TS_FTICK] &
                       timer_control_reg_r[`TAE_TC_FTICK_EN] & ext_on;

    // Priority: aux trap, then countdown, then tick
    // The aux trap is synchronous and ignores the external enable
    // Countdown beats tick; the loser waits on its sticky flag
    always_comb begin
        take = 1'b1;
        cause = TAE_CAUSE_NONE;
        vec = 16'h0000;
        if (aux_exec_i && !machine_state_reg_r[`TAE_MS_AUX]) begin
            cause = TAE_CAUSE_AUX;
            vec = `TAE_VEC_AUX;
        end else if (cdown_req) begin
            cause = TAE_CAUSE_CDOWN;
            vec = `TAE_VEC_CDOWN;
        end else if (ftick_req) begin
            cause = TAE_CAUSE_FTICK;
            vec = `TAE_VEC_FTICK;
        end else begin
            // Nothing pending this cycle
            take = 1'b0;
        end
    end

    // Machine state: entry wins, then return, then bus
    // A bus write in the same cycle as an entry or return is dropped
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            machine_state_reg_r <= `TAE_RST_WORD;
        end else if (take) begin
            // Clearing the external enable blocks further timer entries
            machine_state_reg_r <= entry_state(machine_state_reg_r);
        end else if (rfi_i) begin
            // Normal return restores the saved state
            machine_state_reg_r <= save_restore_state_r;
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_MSTATE)) begin
            // Software update when nothing else claims the register
            machine_state_reg_r <= apb_i.pwdata;
        end
    end

    // Return address save
    // Timer entries save where the program would have gone next
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            save_restore_pc_r <= `TAE_RST_WORD;
        end else if (take) begin
            if (cause == TAE_CAUSE_AUX) begin
                // Faulting instruction, syndrome and fault address untouched
                save_restore_pc_r <= aux_ea_i;
            end else begin
                save_restore_pc_r <= next_pc_i;
            end
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_SRPC)) begin
            // Handler may rewrite the return address
            save_restore_pc_r <= apb_i.pwdata;
        end
    end

    // Saved state; critical save pair is never touched here
    // Holds the state from before the entry, for the return
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            save_restore_state_r <= `TAE_RST_WORD;
        end else if (take) begin
            save_restore_state_r <= machine_state_reg_r;
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_SRSTATE)) begin
            // Handler may edit the saved state before returning
            save_restore_state_r <= apb_i.pwdata;
        end
    end

    // Timer status: write one to clear, hardware set wins
    // Zeros in the written word leave a flag alone
    // An event in the clearing cycle survives, so no expiry is lost
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            timer_status_reg_r <= `TAE_RST_WORD;
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_TSTATUS)) begin
            timer_status_reg_r <= (timer_status_reg_r & ~apb_i.pwdata) | tsr_set;
        end else begin
            timer_status_reg_r <= timer_status_reg_r | tsr_set;
        end
    end

    // Timer control
    // Only the enable, select and reload bits have any effect
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            // All enables off after reset
            timer_control_reg_r <= `TAE_RST_WORD;
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_TCTRL)) begin
            timer_control_reg_r <= apb_i.pwdata;
        end
    end

    // Countdown: bus write, else decrement with optional reload
    // A write in the decrement cycle wins and raises no time-out
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            interval_countdown_r <= `TAE_RST_WORD;
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_CDOWN)) begin
            interval_countdown_r <= apb_i.pwdata;
        end else if (cdown_timeout) begin
            // Reload keeps a periodic stream; zero stops it
            if (timer_control_reg_r[`TAE_TC_RELOAD]) begin
                interval_countdown_r <= cdown_reload_r;
            end else begin
                // One-shot use: the counter stops at zero
                interval_countdown_r <= 32'h0000_0000;
            end
        end else if (cdown_dec_i && interval_countdown_r != 32'h0000_0000) begin
            // Held at zero: a stopped counter never wraps
            interval_countdown_r <= interval_countdown_r - 32'h0000_0001;
        end
    end

    // Reload value
    // Loaded on expiry only while auto-reload is on
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cdown_reload_r <= `TAE_RST_WORD;
        end else if (bus_wr && hit(apb_i.paddr, `TAE_OFF_RELOAD)) begin
            cdown_reload_r <= apb_i.pwdata;
        end
    end

    // Tick history; first cycle after reset only arms, avoids a false edge
    // An edge in the first cycle after reset is not seen
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            // Idle low, like the time-base bits after reset
            tb_prev_r <= 1'b0;
            tb_armed_r <= 1'b0;
        end else begin
            tb_prev_r <= tb_sel;
            tb_armed_r <= 1'b1;
        end
    end

    // Entry notice, one-cycle pulse after the taking edge
    // Registered so the pipeline sees a clean pulse; costs one cycle
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            entry_r <= '0;
        end else begin
            // Cause and vector only mean something with valid
            entry_r.valid <= take;
            entry_r.cause <= cause;
            entry_r.vector <= vec;
        end
    end

    // Read data captured in the setup cycle
    // Sampling at setup keeps the decode off the access-cycle path
    // A register that changes between setup and access reads its old value
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prdata_r <= `TAE_RST_WORD;
        end else if (bus_setup) begin
            // Decode on the low byte; the check below covers the rest
            case (apb_i.paddr[7:0])
                `TAE_OFF_MSTATE: prdata_r <= machine_state_reg_r;
                `TAE_OFF_SRPC: prdata_r <= save_restore_pc_r;
                `TAE_OFF_SRSTATE: prdata_r <= save_restore_state_r;
                `TAE_OFF_TSTATUS: prdata_r <= timer_status_reg_r;
                `TAE_OFF_TCTRL: prdata_r <= timer_control_reg_r;
                `TAE_OFF_CDOWN: prdata_r <= interval_countdown_r;
                `TAE_OFF_RELOAD: prdata_r <= cdown_reload_r;
                default: prdata_r <= 32'h0000_0000;
            endcase
            // Upper address bits must be zero too
            if (!mapped(apb_i.paddr)) begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Error for unmapped addresses, decided at setup
    // Writes to unmapped slots are dropped without side effects
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pslverr_r <= 1'b0;
        end else if (bus_setup) begin
            // Held from setup into the access cycle
            pslverr_r <= !mapped(apb_i.paddr);
        end
    end

    // Zero-wait access phase
    // Every access completes in its first access cycle
    // pslverr is gated so it never shows outside an access
    assign apb_o.pready = apb_i.psel & apb_i.penable;
    assign apb_o.pslverr = pslverr_r & apb_i.psel & apb_i.penable;
    assign apb_o.prdata = prdata_r;
    assign entry_o = entry_r;
    assign machine_state_o = machine_state_reg_r;

endmodule

// ### tae_exception_entry_properties.sv
`timescale 1ns/1ps
module tae_entry_checker
    import tae_pkg::*;
(
    // Clock, reset and bus
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire tae_apb_req_t apb_i,
    input wire tae_apb_rsp_t apb_o,
    // Pipeline and timer
    input wire logic aux_exec_i,
    input wire logic [31:0] aux_ea_i,
    input wire logic [31:0] next_pc_i,
    input wire logic rfi_i,
    input wire logic cdown_dec_i,
    input wire logic [3:0] tb_bits_i,
    // Entry and state
    input wire tae_entry_t entry_o,
    input wire logic [31:0] machine_state_o
);
    // State bits an entry clears, and the enables it keeps
    localparam logic [31:0] CLR_M = 32'h020c_ed30;
    localparam logic [31:0] KEEP_M = 32'h0002_1200;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Timer entry notice in this cycle
    wire logic tmr = entry_o.valid && entry_o.cause != TAE_CAUSE_AUX;

    aux_entry_a: assert property (aux_exec_i && !machine_state_o[25]
        |=> entry_o.valid && entry_o.cause == TAE_CAUSE_AUX) else $error("aux trap missed");
    aux_blocked_a: assert property (aux_exec_i && machine_state_o[25]
        |=> !(entry_o.valid && entry_o.cause == TAE_CAUSE_AUX)) else $error("aux trap unasked");
    vector_map_a: assert property (entry_o.valid |-> entry_o.vector ==
        (entry_o.cause == TAE_CAUSE_AUX ? 16'h0f20 :
        entry_o.cause == TAE_CAUSE_CDOWN ? 16'h1000 : 16'h1010)) else $error("bad vector");
    state_clear_a: assert property (entry_o.valid
        |-> (machine_state_o & CLR_M) == 32'h0) else $error("state bits left set");
    state_keep_a: assert property (entry_o.valid |-> (machine_state_o & KEEP_M)
        == ($past(machine_state_o) & KEEP_M)) else $error("enables lost");
    timer_gate_a: assert property (tmr |-> $past(machine_state_o[15]))
        else $error("timer entry while masked");
    masked_timer_a: assert property (!machine_state_o[15] |=> !tmr)
        else $error("timer entry with mask clear");
    timer_spacing_a: assert property (tmr |=> !tmr)
        else $error("timer entries back to back");

    // Main scenarios reached
    cover property (entry_o.valid && entry_o.cause == TAE_CAUSE_AUX);
    cover property (entry_o.valid && entry_o.cause == TAE_CAUSE_CDOWN);
    cover property (entry_o.valid && entry_o.cause == TAE_CAUSE_FTICK);
endmodule

bind tae_exception_entry tae_entry_checker chk_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .apb_i(apb_i), .apb_o(apb_o),
    .aux_exec_i(aux_exec_i), .aux_ea_i(aux_ea_i), .next_pc_i(next_pc_i),
    .rfi_i(rfi_i), .cdown_dec_i(cdown_dec_i), .tb_bits_i(tb_bits_i),
    .entry_o(entry_o), .machine_state_o(machine_state_o)
);

// ### tae_core_model.sv
`timescale 1ns/1ps
module tae_core_model (
    // Core clock
    input wire logic clk_i,
    // Pipeline and timer lines
    output logic aux_exec_o,
    output logic [31:0] aux_ea_o,
    output logic [31:0] next_pc_o,
    output logic rfi_o,
    output logic cdown_dec_o,
    output logic [3:0] tb_bits_o
);
    // Idle lines at time zero
    initial begin
        {aux_exec_o, rfi_o, cdown_dec_o, tb_bits_o} = '0;
        aux_ea_o = 32'h0;
        next_pc_o = 32'h0000_2000;
    end
    // Pipeline retires a word each cycle, so the next address walks on
    always @(posedge clk_i) begin
        next_pc_o <= next_pc_o + 32'h4;
    end
    // One-cycle strobe: 0 return, 1 decrement, 2 aux instruction
    task automatic strobe(input logic [1:0] k, input logic [31:0] ea);
        @(posedge clk_i);
        rfi_o <= (k == 2'd0);
        cdown_dec_o <= (k == 2'd1);
        aux_exec_o <= (k == 2'd2);
        aux_ea_o <= ea;
        @(posedge clk_i);
        {rfi_o, cdown_dec_o, aux_exec_o} <= 3'b0;
        // Stale address inverted so it cannot pass for a live one
        aux_ea_o <= ~ea;
    endtask
    // Time-base bits move only just after an edge
    task automatic set_tb(input logic [3:0] v);
        @(posedge clk_i);
        tb_bits_o <= v;
    endtask
endmodule

// ### tae_exception_entry_tb.sv
`timescale 1ns/1ps
module tae_exception_entry_tb
    import tae_pkg::*;
;
    localparam logic [31:0] CLR_M = 32'h020c_ed30;
    // Busy machine state, aux unit and interrupts on
    localparam logic [31:0] MS0 = 32'h020e_fb30;
    localparam logic [17:0] CD = {2'b10, 16'h1000};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    tae_apb_req_t req = '0;
    tae_apb_rsp_t rsp;
    tae_entry_t ent;
    logic [31:0] ms;
    logic aux_exec, rfi, dec;
    logic [31:0] ea, npc;
    logic [3:0] tbb;
    logic [31:0] n_errors = 0, cmp_count = 0, n_ent = 0, ent_pc = 0;
    logic [17:0] last_ent = '0;

    initial begin
        forever #50 clk = ~clk;
    end

    tae_core_model core_u (.clk_i(clk), .aux_exec_o(aux_exec), .aux_ea_o(ea),
        .next_pc_o(npc), .rfi_o(rfi), .cdown_dec_o(dec), .tb_bits_o(tbb));
    tae_exception_entry dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .apb_i(req),
        .apb_o(rsp), .aux_exec_i(aux_exec), .aux_ea_i(ea), .next_pc_i(npc),
        .rfi_i(rfi), .cdown_dec_i(dec), .tb_bits_i(tbb), .entry_o(ent),
        .machine_state_o(ms));

    // Log entries and the address a timer entry ought to save
    always @(posedge clk) begin
        if (rst_b && ent.valid === 1'b1) begin
            n_ent <= n_ent + 1;
            last_ent <= {ent.cause, ent.vector};
            ent_pc <= npc - 32'h4;
        end
    end

    task automatic complete_run();
        if (n_errors == 0 && cmp_count != 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int i;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {24'h0, a}, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (rsp.pready !== 1'b1 && i < 16);
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        if (rsp.pready !== 1'b1) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // Let an entry settle, then check count and last cause with vector
    task automatic ents(input logic [31:0] n, input logic [17:0] cv);
        repeat (4) @(posedge clk);
        chk(n_ent, n);
        chk({14'h0, last_ent}, {14'h0, cv});
    endtask

    initial begin
        logic [31:0] r;
        logic e;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, then an unmapped slot refused
        for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
        apb(1'b1, 8'h1c, 32'hffff_ffff, r, e);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h8000_0000);
        // Countdown time-out with its enable and the external enable on
        wr(8'h10, 32'h0400_0000);
        wr(8'h00, MS0);
        wr(8'h14, 32'h1);
        core_u.strobe(2'd1, 32'h0);
        ents(1, CD);
        rd(8'h04, ent_pc);
        rd(8'h08, MS0);
        rd(8'h00, MS0 & ~CLR_M);
        rd(8'h0c, 32'h0800_0000);
        rd(8'h14, 32'h0);
        // Flag still set: masked now, taken again after return
        ents(1, CD);
        core_u.strobe(2'd0, 32'h0);
        ents(2, CD);
        wr(8'h0c, 32'h0800_0000);
        core_u.strobe(2'd0, 32'h0);
        ents(2, CD);
        // Software zero write in the cycle of a decrement from one, then one at zero
        wr(8'h14, 32'h1);
        fork
            begin
                @(posedge clk);
                core_u.strobe(2'd1, 32'h0);
            end
            wr(8'h14, 32'h0);
        join
        core_u.strobe(2'd1, 32'h0);
        ents(2, CD);
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h0);
        // Time-out with its enable off, auto-reload on, stays pending until enabled
        wr(8'h10, 32'h0040_0000);
        wr(8'h18, 32'h3);
        wr(8'h14, 32'h1);
        core_u.strobe(2'd1, 32'h0);
        ents(2, CD);
        rd(8'h14, 32'h3);
        rd(8'h0c, 32'h0800_0000);
        wr(8'h10, 32'h0480_0000);
        ents(3, CD);
        // Tick while masked, then both pending after return
        core_u.set_tb(4'h1);
        ents(3, CD);
        rd(8'h0c, 32'h0c00_0000);
        core_u.strobe(2'd0, 32'h0);
        ents(4, CD);
        wr(8'h0c, 32'h0800_0000);
        core_u.strobe(2'd0, 32'h0);
        ents(5, {2'b11, 16'h1010});
        rd(8'h04, ent_pc);
        rd(8'h0c, 32'h0400_0000);
        wr(8'h0c, 32'h0400_0000);
        core_u.strobe(2'd0, 32'h0);
        ents(5, {2'b11, 16'h1010});
        // Aux instruction with the unit on, then off
        core_u.strobe(2'd2, 32'h0000_4a40);
        ents(5, {2'b11, 16'h1010});
        wr(8'h00, MS0 & ~32'h0200_0000);
        core_u.strobe(2'd2, 32'h0000_4a44);
        ents(6, {2'b01, 16'h0f20});
        rd(8'h04, 32'h0000_4a44);
        rd(8'h08, MS0 & ~32'h0200_0000);
        chk(ms, MS0 & ~32'h0200_0000 & ~CLR_M);
        complete_run();
    end
endmodule
